// ### hw/cpw_params.svh
`ifndef CPW_PARAMS_SVH
`define CPW_PARAMS_SVH
// register byte offsets
`define CPW_OFF_CTRL 8'h00
`define CPW_OFF_DUTY_LO 8'h04
`define CPW_OFF_DUTY_HI 8'h08
`define CPW_OFF_TSEL 8'h0c
`define CPW_OFF_TMR_BASE 8'h10
`define CPW_TMR_STRIDE 8'h08
`define CPW_OFF_PERIOD 8'h04
`define CPW_OFF_FLAGS 8'h28
// module_control fields
`define CPW_CTRL_EN 7
`define CPW_CTRL_OUT 5
`define CPW_CTRL_FMT 4
`define CPW_MODE_PWM 4'hf
`define CPW_MODE_OFF 4'h0
// timer_control fields
`define CPW_TC_RUN 2
`define CPW_TC_CNT_LSB 8
// timer select register fields and reset values
`define CPW_TSEL_PINDIR 4
`define CPW_TSEL_RST 2'h1
`define CPW_PINDIR_RST 1'b1
`define CPW_PERIOD_RST 8'hff
`define CPW_DUTY_RST 8'h00
// timing
`define CPW_CLK_NS 40
`define CPW_INST_NS 160
`define CPW_INST_CYC ((`CPW_INST_NS + `CPW_CLK_NS - 1) / `CPW_CLK_NS)
`define CPW_NUM_TMR 3
`endif

// ### hw/cpw_pkg.sv
package cpw_pkg;
   typedef enum logic [1:0] {
      CPW_PS1 = 2'b00,
      CPW_PS4 = 2'b01,
      CPW_PS16 = 2'b10,
      CPW_PS64 = 2'b11
   } cpw_ps_t;
   typedef struct packed {
      logic run;
      cpw_ps_t ps;
   } cpw_tcfg_t;
   typedef struct packed {
      logic valid;
      logic wr;
      logic [7:0] addr;
   } cpw_dphase_t;
endpackage

// ### hw/cpw_pwm.sv
// Overview of operation
// - pulse-width modulated output with up to ten bits of duty resolution
// - period is (period_register+1) times four clocks times prescale factor
// - timer equal to period_register clears on next increment, new period
// - rollover drives pin high unless buffered duty is zero
// - duty bytes writable anytime, copied to 10-bit buffer only at rollover
// - alignment bit selects where the 10-bit duty sits in the two bytes
// - align 0: low[7:0] and high[1:0]; align 1: high[7:0] and low[7:6]
// - time base is timer plus two low bits from clock phase or prescaler
// - time base equal to buffered duty drives pin low for rest of period
// - duty beyond period never matches, so the pin is left unchanged
// - postscaler has no influence; only prescaler and period set period
// - module picks one of three 8-bit auto-reload timers via select register
// - resolution is log2 of 4*(period_register+1), ten bits at 255
// - waveform reaches pin only while pin direction bit is cleared
// - sleep freezes timer and module state, pin holds, resumes afterwards
// - mode 1111 selects pwm, mode 0000 turns off and resets module state
// - current output level readable as status bit in module_control
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cpw_params.svh"
module cpw_pwm
   import cpw_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_sleep,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic o_pwm_output_pin,
   output logic o_pwm_output_pin_oe
);
   localparam int NT = `CPW_NUM_TMR;

   logic run_ce;
   logic [1:0] phase_r;
   logic [1:0] phase_nxt;
   logic inst_tick;
   cpw_dphase_t dp_r;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] rd_nxt;
   logic [31:0] hrdata_r;
   logic ctrl_en_r;
   logic ctrl_fmt_r;
   logic [3:0] mode_r;
   logic [7:0] duty_lo_r;
   logic [7:0] duty_hi_r;
   logic [1:0] tsel_r;
   logic pin_dir_r;
   logic [9:0] duty_val;
   logic [9:0] duty_buf_r;
   logic out_r;
   logic pwm_on;
   logic [1:0] sel_idx;
   logic sel_roll;
   logic [9:0] sel_tb;
   logic [NT-1:0] tmr_roll;
   logic [NT-1:0] tmr_flag;
   logic [NT-1:0][9:0] tmr_tb;
   logic [NT-1:0][31:0] tmr_rd_ctrl;
   logic [NT-1:0][31:0] tmr_rd_per;

   // sleep stops counting but leaves the bus alive so software can inspect
   assign run_ce = i_ce & ~i_sleep;
   assign phase_nxt = run_ce ? phase_r + 2'h1 : phase_r;

   // quarter-rate instruction clock phase, also the 1:1 low time base bits
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_nxt;
      end
   end
   assign inst_tick = (32'(phase_r) == `CPW_INST_CYC - 1);

   // ahb-lite slave: zero wait states, always okay
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = hrdata_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         dp_r <= '0;
      end else if (i_ce && i_hready) begin
         dp_r.valid <= i_hsel & i_htrans[1];
         dp_r.wr <= i_hwrite;
         dp_r.addr <= i_haddr[7:0];
      end
   end
   assign wr_en = i_ce & dp_r.valid & dp_r.wr;
   assign wr_addr = dp_r.addr;

   // read data is sampled in the address phase so it stands in the data
   // phase; a read directly behind a write to the same word sees old data
   always_comb begin
      rd_nxt = 32'h0;
      case (i_haddr[7:0])
         `CPW_OFF_CTRL: begin
            rd_nxt[`CPW_CTRL_EN] = ctrl_en_r;
            rd_nxt[`CPW_CTRL_OUT] = out_r;
            rd_nxt[`CPW_CTRL_FMT] = ctrl_fmt_r;
            rd_nxt[3:0] = mode_r;
         end
         `CPW_OFF_DUTY_LO: rd_nxt[7:0] = duty_lo_r;
         `CPW_OFF_DUTY_HI: rd_nxt[7:0] = duty_hi_r;
         `CPW_OFF_TSEL: begin
            rd_nxt[1:0] = tsel_r;
            rd_nxt[`CPW_TSEL_PINDIR] = pin_dir_r;
         end
         `CPW_OFF_FLAGS: rd_nxt[NT-1:0] = tmr_flag;
         default: begin
            for (int k = 0; k < NT; k++) begin
               if (i_haddr[7:0] == `CPW_OFF_TMR_BASE + 8'(k) * `CPW_TMR_STRIDE) begin
                  rd_nxt = tmr_rd_ctrl[k];
               end
               if (i_haddr[7:0] == `CPW_OFF_TMR_BASE + 8'(k) * `CPW_TMR_STRIDE
                     + `CPW_OFF_PERIOD) begin
                  rd_nxt = tmr_rd_per[k];
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hrdata_r <= 32'h0;
      end else if (i_ce && i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
         hrdata_r <= rd_nxt;
      end
   end

   // module_control
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctrl_en_r <= 1'b0;
         ctrl_fmt_r <= 1'b0;
         mode_r <= `CPW_MODE_OFF;
      end else if (wr_en && wr_addr == `CPW_OFF_CTRL) begin
         ctrl_en_r <= i_hwdata[`CPW_CTRL_EN];
         ctrl_fmt_r <= i_hwdata[`CPW_CTRL_FMT];
         mode_r <= i_hwdata[3:0];
      end
   end

   // duty bytes may change at any time; only the buffer feeds the compare
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         duty_lo_r <= `CPW_DUTY_RST;
         duty_hi_r <= `CPW_DUTY_RST;
      end else if (wr_en) begin
         if (wr_addr == `CPW_OFF_DUTY_LO) begin
            duty_lo_r <= i_hwdata[7:0];
         end
         if (wr_addr == `CPW_OFF_DUTY_HI) begin
            duty_hi_r <= i_hwdata[7:0];
         end
      end
   end

   // timer select and pin direction; direction resets to input
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tsel_r <= `CPW_TSEL_RST;
         pin_dir_r <= `CPW_PINDIR_RST;
      end else if (wr_en && wr_addr == `CPW_OFF_TSEL) begin
         tsel_r <= i_hwdata[1:0];
         pin_dir_r <= i_hwdata[`CPW_TSEL_PINDIR];
      end
   end

   // three auto-reload timers, each with its own prescaler and period
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tmr
         localparam logic [7:0] BASE = `CPW_OFF_TMR_BASE + 8'(gi) * `CPW_TMR_STRIDE;
         cpw_tcfg_t cfg_r;
         logic [7:0] per_r;
         logic [7:0] cnt_r;
         logic [5:0] pre_r;
         logic [5:0] pre_lim;
         logic [5:0] pre_nxt;
         logic [7:0] cnt_nxt;
         logic [1:0] low2;
         logic step;
         logic flag_r;

         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               cfg_r <= '0;
               per_r <= `CPW_PERIOD_RST;
            end else if (wr_en) begin
               if (wr_addr == BASE) begin
                  cfg_r <= cpw_tcfg_t'(i_hwdata[2:0]);
               end
               if (wr_addr == BASE + `CPW_OFF_PERIOD) begin
                  per_r <= i_hwdata[7:0];
               end
            end
         end

         always_comb begin
            case (cfg_r.ps)
               CPW_PS1: pre_lim = 6'h00;
               CPW_PS4: pre_lim = 6'h03;
               CPW_PS16: pre_lim = 6'h0f;
               default: pre_lim = 6'h3f;
            endcase
         end

         // no postscaler exists here: the period depends on prescale and per_r only
         assign step = run_ce & cfg_r.run & inst_tick & (pre_r == pre_lim);
         assign pre_nxt = !(run_ce && cfg_r.run && inst_tick) ? pre_r
                        : (pre_r == pre_lim) ? 6'h0 : pre_r + 6'h1;
         assign cnt_nxt = !step ? cnt_r : (cnt_r == per_r) ? 8'h0 : cnt_r + 8'h1;

         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               pre_r <= 6'h0;
               cnt_r <= 8'h0;
            end else begin
               pre_r <= pre_nxt;
               cnt_r <= cnt_nxt;
            end
         end

         // low time base bits as they will stand after this edge
         always_comb begin
            case (cfg_r.ps)
               CPW_PS1: low2 = phase_nxt;
               CPW_PS4: low2 = pre_nxt[1:0];
               CPW_PS16: low2 = pre_nxt[3:2];
               default: low2 = pre_nxt[5:4];
            endcase
         end

         // overflow flag: write one to clear, a new rollover wins the clear
         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               flag_r <= 1'b0;
            end else if (i_ce) begin
               if (tmr_roll[gi]) begin
                  flag_r <= 1'b1;
               end else if (wr_en && wr_addr == `CPW_OFF_FLAGS && i_hwdata[gi]) begin
                  flag_r <= 1'b0;
               end
            end
         end

         assign tmr_roll[gi] = step & (cnt_r == per_r);
         assign tmr_tb[gi] = {cnt_nxt, low2};
         assign tmr_flag[gi] = flag_r;
         assign tmr_rd_ctrl[gi] = {16'h0, cnt_r, 5'h0, cfg_r};
         assign tmr_rd_per[gi] = {24'h0, per_r};
      end
   endgenerate

   // code 00 is reserved and falls back to the first timer
   assign sel_idx = (tsel_r == 2'h0) ? 2'h0 : tsel_r - 2'h1;
   assign sel_roll = tmr_roll[sel_idx];
   assign sel_tb = tmr_tb[sel_idx];

   assign duty_val = ctrl_fmt_r ? {duty_hi_r, duty_lo_r[7:6]}
                                : {duty_hi_r[1:0], duty_lo_r};
   assign pwm_on = ctrl_en_r & (mode_r == `CPW_MODE_PWM);

   // a duty above the period never equals the time base, so no clear fires
   // the compare sees the time base of the coming cycle: a registered pin
   // would otherwise stay high one clock past the duty
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         duty_buf_r <= 10'h0;
         out_r <= 1'b0;
      end else if (i_ce && !pwm_on) begin
         duty_buf_r <= 10'h0;
         out_r <= 1'b0;
      end else if (run_ce) begin
         if (sel_roll) begin
            duty_buf_r <= duty_val;
            out_r <= (duty_val != 10'h0);
         end else if (sel_tb == duty_buf_r) begin
            out_r <= 1'b0;
         end
      end
   end

   assign o_pwm_output_pin = out_r;
   assign o_pwm_output_pin_oe = ~pin_dir_r;
endmodule
`default_nettype wire

// ### sim/cpw_pwm_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cpw_pwm_assertions
   import cpw_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_sleep,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [31:0] o_hrdata,
   input wire logic o_pwm_output_pin,
   input wire logic o_pwm_output_pin_oe
);
   cpw_dphase_t dph_r;
   logic [7:0] ctl_r;
   logic oe_exp_r;
   wire logic take = i_ce & i_hready & i_hsel & i_htrans[1];
   wire logic off = !(ctl_r[7] && ctl_r[3:0] == 4'hf);
   wire logic dwr = dph_r.valid && dph_r.wr;
   // shadow of the bus writes, so pin behaviour can be tied to what software asked for
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         dph_r <= '0;
         ctl_r <= 8'h00;
         oe_exp_r <= 1'b0;
      end else if (i_ce) begin
         dph_r <= {take, i_hwrite, i_haddr[7:0]};
         if (dwr && dph_r.addr == 8'h00) ctl_r <= i_hwdata[7:0];
         if (dwr && dph_r.addr == 8'h0c) oe_exp_r <= !i_hwdata[4];
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   AST_READY:
      assert property (o_hreadyout) else $error("wait state inserted");
   AST_RESP:
      assert property (!o_hresp) else $error("error response");
   AST_RST_OUT:
      assert property ($fell(i_rst) |-> !o_pwm_output_pin && !o_pwm_output_pin_oe
         && o_hrdata == 32'h0) else $error("outputs not at reset state");
   AST_SLEEP_HOLD:
      assert property (i_sleep && i_ce |=> $stable(o_pwm_output_pin))
         else $error("pin moved in sleep");
   AST_CE_HOLD:
      assert property (!i_ce |=> $stable(o_pwm_output_pin) && $stable(o_hrdata))
         else $error("state moved with clock enable low");
   AST_OE:
      assert property (dwr && dph_r.addr == 8'h0c |=> ##[0:1]
         o_pwm_output_pin_oe == oe_exp_r) else $error("pin enable wrong");
   AST_STATUS:
      assert property (take && !i_hwrite && i_haddr[7:0] == 8'h00 |=>
         o_hrdata[5] == $past(o_pwm_output_pin)) else $error("status bit wrong");
   AST_MODE_OFF:
      assert property (off && $past(off) && $past(off, 2) |-> !o_pwm_output_pin)
         else $error("pin high while off");
endmodule
bind cpw_pwm cpw_pwm_assertions u_cpw_pwm_assertions (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_ce(i_ce), .i_sleep(i_sleep), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_pwm_output_pin(o_pwm_output_pin),
   .o_pwm_output_pin_oe(o_pwm_output_pin_oe));
`default_nettype wire

// ### sim/cpw_load_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpw_load_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_lvl,
   output logic [15:0] o_hi_len,
   output logic [15:0] o_per_len,
   output logic [7:0] o_rises
);
   logic [15:0] cnt_r;
   logic [15:0] hi_r;
   logic lvl_d_r;
   // lengths are those of the period that ended at the latest rising edge
   always_ff @(posedge i_clk_sys) begin
      lvl_d_r <= i_lvl;
      if (i_rst) begin
         o_rises <= 8'h0;
         lvl_d_r <= 1'b1;
      end else if (i_lvl && !lvl_d_r) begin
         o_hi_len <= hi_r;
         o_per_len <= cnt_r;
         o_rises <= o_rises + 8'h1;
         cnt_r <= 16'h1;
         hi_r <= 16'h1;
      end else begin
         cnt_r <= cnt_r + 16'h1;
         hi_r <= hi_r + {15'h0, i_lvl};
      end
   end
endmodule
`default_nettype wire

// ### sim/cpw_pwm_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cpw_pwm_bench;
   typedef struct {int t, pr, ps, d, f, hi, per;} cpw_case_t;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_sleep = 1'b0;
   logic i_hsel = 1'b0, i_hwrite = 1'b0;
   logic [1:0] i_htrans = 2'h0;
   logic [2:0] i_hsize = 3'h2;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, q;
   logic o_hreadyout, o_hresp, o_pwm_output_pin, o_pwm_output_pin_oe;
   logic [15:0] hi_len, per_len;
   logic [7:0] rises, r;
   int err_count = 0, total_checks = 0, cyc = 0, h;
   int ra[5] = '{'h00, 'h0c, 'h14, 'h28, 'h2c};
   int rv[5] = '{'h00, 'h11, 'hff, 'h00, 'h00};
   // a timer only ever grows its period, so no count is left above a new limit
   cpw_case_t tc[7] = '{'{0, 0, 2, 3, 1, 48, 64}, '{0, 0, 3, 1, 0, 64, 256},
      '{0, 1, 0, 3, 0, 3, 8}, '{0, 1, 0, 5, 1, 5, 8}, '{0, 1, 1, 5, 0, 20, 32},
      '{1, 3, 0, 6, 0, 6, 16}, '{2, 0, 0, 2, 1, 2, 4}};
   cpw_case_t cx = '{0, 1, 0, 10, 0, 0, 0};
   initial forever #20 i_clk_sys = ~i_clk_sys;
   // the one slave's ready is the bus's ready
   cpw_pwm u_cpw_pwm (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_sleep(i_sleep),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
      .o_pwm_output_pin(o_pwm_output_pin), .o_pwm_output_pin_oe(o_pwm_output_pin_oe));
   // a released pin reads low through the load's pull-down
   cpw_load_model u_cpw_load_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_lvl(o_pwm_output_pin_oe & o_pwm_output_pin), .o_hi_len(hi_len),
      .o_per_len(per_len), .o_rises(rises));
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] g, input int e);
      total_checks++;
      if (g !== 32'(e)) begin
         err_count++;
         $display("MISMATCH %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic bus(input int a, input int d, input logic w);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= 32'(a);
      i_hwrite <= w;
      @(posedge i_clk_sys);
      while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
      i_htrans <= 2'h0;
      i_hwdata <= 32'(d);
      @(posedge i_clk_sys);
      while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
      q = o_hrdata;
      @(posedge i_clk_sys);
   endtask
   task automatic cfg(input cpw_case_t c);
      bus('h14 + 8 * c.t, c.pr, 1);
      bus('h28, 'h7, 1);
      bus('h10 + 8 * c.t, 'h4 + c.ps, 1);
      bus('h04, c.f ? (c.d & 'h3) << 6 : c.d & 'hff, 1);
      bus('h08, c.f ? c.d >> 2 : c.d >> 8, 1);
      bus('h00, 'h8f + 'h10 * c.f, 1);
      do bus('h28, 0, 0); while (q[c.t] !== 1'b1);
      bus('h0c, c.t + 1, 1);
   endtask
   task automatic meas;
      r = rises;
      while (rises !== r + 8'h3) @(posedge i_clk_sys);
   endtask
   task automatic hcnt(input int n);
      h = 0;
      repeat (n) begin
         @(negedge i_clk_sys);
         h += o_pwm_output_pin;
      end
      @(posedge i_clk_sys);
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 10000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      foreach (ra[i]) begin
         bus(ra[i], 0, 0);
         chk("reset value", q, rv[i]);
      end
      $display("test reset done");
      foreach (tc[i]) begin
         cfg(tc[i]);
         meas();
         chk("high time", 32'(hi_len), tc[i].hi);
         chk("period", 32'(per_len), tc[i].per);
      end
      $display("test periods done");
      i_sleep <= 1'b1;
      repeat (40) @(posedge i_clk_sys);
      i_sleep <= 1'b0;
      i_ce <= 1'b0;
      repeat (20) @(posedge i_clk_sys);
      i_ce <= 1'b1;
      meas();
      chk("wake high", 32'(hi_len), 2);
      chk("wake period", 32'(per_len), 4);
      $display("test sleep done");
      cfg(cx);
      hcnt(24);
      chk("long duty", 32'(h), 24);
      bus('h00, 0, 0);
      chk("status", q, 'haf);
      bus('h00, 0, 1);
      repeat (2) @(posedge i_clk_sys);
      hcnt(16);
      chk("off level", 32'(h), 0);
      bus('h00, 0, 0);
      chk("off status", q, 'h00);
      cx.d = 0;
      cfg(cx);
      hcnt(24);
      chk("zero duty", 32'(h), 0);
      $display("test limits done");
      test_done();
   end
endmodule
`default_nettype wire
